// ---- stmcr_pkg.sv ----
package stmcr_pkg;
  // register index map over the plain port
  localparam logic [2:0] ADDR_CONTROL    = 3'h0;
  localparam logic [2:0] ADDR_MODE_OUT   = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LOW  = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
  localparam logic [2:0] ADDR_MATCH_LOW  = 3'h4;
  localparam logic [2:0] ADDR_MATCH_HIGH = 3'h5;
  localparam logic [2:0] ADDR_PERIOD     = 3'h6;
  localparam logic [2:0] ADDR_FLAGS      = 3'h7;
  // mode_output_control field positions
  localparam int MODE_HI_POS   = 7;
  localparam int MODE_LO_POS   = 6;
  localparam int FUNC_HI_POS   = 5;
  localparam int FUNC_LO_POS   = 4;
  localparam int LEVEL_POS     = 3;
  localparam int INVERT_POS    = 2;
  localparam int SWAP_POS      = 1;
  localparam int CLR_SRC_POS   = 0;
  // control register field positions
  localparam int PAUSE_POS     = 7;
  localparam int RUN_POS       = 3;
  // flag register positions (write one to clear)
  localparam int FLAG_A_POS    = 0;
  localparam int FLAG_P_POS    = 1;
  // reset values
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  // mode codes
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_COUNTER = 2'h3;
  // pin function codes
  localparam logic [1:0] FUNC_00 = 2'h0;
  localparam logic [1:0] FUNC_01 = 2'h1;
  localparam logic [1:0] FUNC_10 = 2'h2;
  localparam logic [1:0] FUNC_11 = 2'h3;
endpackage

// ---- stmcr_timer.sv ----
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module stmcr_timer
  import stmcr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer_tick,
  input  wire logic       timer_io_pin_in,
  output logic            timer_io_pin_out,
  output logic            timer_io_pin_oe_n,
  output logic            compare_a_flag,
  output logic            compare_p_flag,
  output logic            capture_event
);
  import stmcr_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  mode_output_control;
    logic [15:0] compare_a_value;
    logic [7:0]  period_compare_value;
    logic [15:0] count;
    logic [15:0] capture_value;
    logic        pin_state;
    logic        pulse_on;
    logic        flag_a;
    logic        flag_p;
    logic        cap_evt;
    logic        pin_sync1;
    logic        pin_sync2;
    logic        pin_prev;
    logic        tick_sync1;
    logic        tick_sync2;
    logic        tick_prev;
    logic [7:0]  rdata;
  } stmcr_state_t;

  stmcr_state_t state;
  stmcr_state_t next_state;

  logic [1:0] op_select;
  logic [1:0] pin_function;
  logic       output_level_control;
  logic       output_invert;
  logic       period_duty_swap;
  logic       clear_source_select;
  logic       run_bit;
  logic       pause_bit;
  logic       run_rise;
  logic       tick;
  logic       match_a;
  logic       match_p;
  logic       overflow;
  logic       period_zero;
  logic       clear_count;
  logic       pin_rise;
  logic       pin_fall;
  logic       capture_hit;
  logic       pwm_active;
  logic [16:0] pwm_period;
  logic [16:0] pwm_duty;
  logic       raw_pin;

  assign op_select            = state.mode_output_control[MODE_HI_POS:MODE_LO_POS];
  assign pin_function         = state.mode_output_control[FUNC_HI_POS:FUNC_LO_POS];
  assign output_level_control = state.mode_output_control[LEVEL_POS];
  assign output_invert        = state.mode_output_control[INVERT_POS];
  assign period_duty_swap     = state.mode_output_control[SWAP_POS];
  assign clear_source_select  = state.mode_output_control[CLR_SRC_POS];
  assign run_bit              = state.ctrl[RUN_POS];
  assign pause_bit            = state.ctrl[PAUSE_POS];
  assign tick                 = state.tick_sync2 & ~state.tick_prev;
  assign period_zero          = (state.period_compare_value == RESET_BYTE);
  // comparisons count only on the tick that reaches the value
  assign match_a  = tick && run_bit && !pause_bit
                    && (state.count + 16'h0001 == state.compare_a_value);
  assign match_p  = tick && run_bit && !pause_bit && !period_zero
                    && (state.count[7:0] == 8'hff)
                    && (state.count[15:8] + 8'h01 == state.period_compare_value);
  assign overflow = tick && run_bit && !pause_bit && (state.count == 16'hffff);

  always_comb begin
    // pwm: period value spans whole 256-count blocks, zero means full range
    pwm_period = period_zero ? 17'h10000 : {1'b0, state.period_compare_value, 8'h00};
    pwm_duty   = {1'b0, state.compare_a_value};
    if (period_duty_swap) begin
      pwm_period = {1'b0, state.compare_a_value};
      pwm_duty   = period_zero ? 17'h10000 : {1'b0, state.period_compare_value, 8'h00};
    end
  end

  always_comb begin
    clear_count = 1'b0;
    unique case (op_select)
      MODE_COMPARE, MODE_COUNTER: begin
        if (clear_source_select)
          clear_count = match_a;
        else
          clear_count = match_p | (period_zero & overflow);
      end
      MODE_PWM: begin
        clear_count = period_duty_swap ? match_a : (match_p | (period_zero & overflow));
      end
      MODE_CAPTURE: begin
        clear_count = 1'b0;
      end
    endcase
  end

  assign run_rise    = reg_write && (reg_addr == ADDR_CONTROL) && reg_wdata[RUN_POS] && !run_bit;
  assign pin_rise    = state.pin_sync2 & ~state.pin_prev;
  assign pin_fall    = ~state.pin_sync2 & state.pin_prev;
  always_comb begin
    unique case (pin_function)
      FUNC_00: capture_hit = pin_rise;
      FUNC_01: capture_hit = pin_fall;
      FUNC_10: capture_hit = pin_rise | pin_fall;
      FUNC_11: capture_hit = 1'b0;
    endcase
  end
  assign pwm_active = ({1'b0, state.count} < pwm_duty) || (pwm_duty >= pwm_period);

  always_comb begin
    next_state            = state;
    next_state.cap_evt    = 1'b0;
    // async inputs pass two flops before the edge detectors read them
    next_state.pin_sync1  = timer_io_pin_in;
    next_state.pin_sync2  = state.pin_sync1;
    next_state.pin_prev   = state.pin_sync2;
    next_state.tick_sync1 = timer_tick;
    next_state.tick_sync2 = state.tick_sync1;
    next_state.tick_prev  = state.tick_sync2;
    if (tick && run_bit && !pause_bit) begin
      next_state.count = clear_count ? RESET_COUNT : state.count + 16'h0001;
    end
    if (match_a && op_select != MODE_CAPTURE)
      next_state.flag_a = 1'b1;
    if (match_p && !((op_select == MODE_COMPARE || op_select == MODE_COUNTER) && clear_source_select))
      next_state.flag_p = 1'b1;
    if (op_select == MODE_COMPARE && match_a) begin
      unique case (pin_function)
        FUNC_00: next_state.pin_state = state.pin_state;
        FUNC_01: next_state.pin_state = 1'b0;
        FUNC_10: next_state.pin_state = 1'b1;
        FUNC_11: next_state.pin_state = ~state.pin_state;
      endcase
    end
    // single pulse ends on match A or when run drops
    if (match_a && op_select == MODE_PWM)
      next_state.pulse_on = 1'b0;
    if (op_select == MODE_CAPTURE && run_bit && capture_hit) begin
      next_state.capture_value = state.count;
      next_state.cap_evt       = 1'b1;
    end
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_CONTROL: begin
          next_state.ctrl = {reg_wdata[PAUSE_POS:RUN_POS], 3'h0};
          if (run_rise) begin
            next_state.count     = RESET_COUNT;
            next_state.pin_state = output_level_control;
            next_state.pulse_on  = 1'b1;
          end
          if (!reg_wdata[RUN_POS])
            next_state.pulse_on = 1'b0;
        end
        ADDR_MODE_OUT:   next_state.mode_output_control          = reg_wdata;
        ADDR_MATCH_LOW:  next_state.compare_a_value[7:0]         = reg_wdata;
        ADDR_MATCH_HIGH: next_state.compare_a_value[15:8]        = reg_wdata;
        ADDR_PERIOD:     next_state.period_compare_value         = reg_wdata;
        ADDR_FLAGS: begin
          // a match in the same cycle keeps its flag set
          if (reg_wdata[FLAG_A_POS] && !match_a)
            next_state.flag_a = 1'b0;
          if (reg_wdata[FLAG_P_POS] && !match_p)
            next_state.flag_p = 1'b0;
        end
        default: ;
      endcase
    end
    next_state.rdata = RESET_BYTE;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_CONTROL:    next_state.rdata = state.ctrl;
        ADDR_MODE_OUT:   next_state.rdata = state.mode_output_control;
        ADDR_COUNT_LOW:  next_state.rdata = state.count[7:0];
        ADDR_COUNT_HIGH: next_state.rdata = state.count[15:8];
        ADDR_MATCH_LOW:  next_state.rdata = state.compare_a_value[7:0];
        ADDR_MATCH_HIGH: next_state.rdata = state.compare_a_value[15:8];
        ADDR_PERIOD:     next_state.rdata = state.period_compare_value;
        ADDR_FLAGS:      next_state.rdata = {6'h00, state.flag_p, state.flag_a};
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    raw_pin = 1'b0;
    unique case (op_select)
      MODE_COMPARE: raw_pin = state.pin_state;
      MODE_PWM: begin
        unique case (pin_function)
          FUNC_00: raw_pin = ~output_level_control;
          FUNC_01: raw_pin = output_level_control;
          FUNC_10: raw_pin = (run_bit && pwm_active) ? output_level_control : ~output_level_control;
          FUNC_11: raw_pin = state.pulse_on && run_bit ? output_level_control : ~output_level_control;
        endcase
      end
      MODE_CAPTURE, MODE_COUNTER: raw_pin = 1'b0;
    endcase
  end

  // pin tristated where it is an input or unused
  // counter mode leaves the pin alone, so the invert bit must not reach it
  assign timer_io_pin_out  = (op_select == MODE_COUNTER) ? 1'b0 : (raw_pin ^ output_invert);
  assign timer_io_pin_oe_n = (op_select == MODE_CAPTURE) || (op_select == MODE_COUNTER);
  assign reg_rdata         = state.rdata;
  assign compare_a_flag    = state.flag_a;
  assign compare_p_flag    = state.flag_p;
  assign capture_event     = state.cap_evt;

  // multi-step checks are built from these small sequences
  sequence counting_s;
    tick && run_bit && !pause_bit && !reg_write;
  endsequence

  sequence at_top_s;
    state.count == 16'hffff;
  endsequence

  sequence count_zero_s;
    state.count == RESET_COUNT;
  endsequence

  sequence compare_mode_s;
    op_select == MODE_COMPARE;
  endsequence

  run_rise_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    run_rise |=> count_zero_s)
    else $error("count not zeroed on run rise");

  run_rise_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
    run_rise && op_select == MODE_COMPARE && !(reg_write && reg_addr == ADDR_MODE_OUT)
    |=> state.pin_state == $past(output_level_control))
    else $error("pin not restored");

  count_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !run_bit && !run_rise |=> $stable(state.count))
    else $error("count moved while off");

  count_inc_a: assert property (@(posedge clk_sys) disable iff (srst)
    tick && run_bit && !pause_bit && !clear_count && !reg_write
    |=> state.count == $past(state.count) + 16'h0001)
    else $error("count not incremented");

  pause_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    run_bit && pause_bit && !reg_write |=> $stable(state.count))
    else $error("count moved while paused");

  wrap_top_a: assert property (@(posedge clk_sys) disable iff (srst)
    counting_s ##0 at_top_s |=> count_zero_s)
    else $error("count did not wrap at top");

  clear_a_a: assert property (@(posedge clk_sys) disable iff (srst)
    match_a && clear_source_select && op_select == MODE_COMPARE && !reg_write
    |=> count_zero_s)
    else $error("no clear on match a");

  clear_p_a: assert property (@(posedge clk_sys) disable iff (srst)
    compare_mode_s ##0 (match_p && !clear_source_select && !reg_write)
    |=> count_zero_s)
    else $error("no clear on match p");

  no_flag_p_a: assert property (@(posedge clk_sys) disable iff (srst)
    compare_mode_s ##0 (clear_source_select && !state.flag_p) |=> !state.flag_p)
    else $error("flag p raised");

  flag_a_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    match_a && op_select != MODE_CAPTURE |=> state.flag_a)
    else $error("flag a not raised on match");

  toggle_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_COMPARE && match_a && pin_function == FUNC_11 && !reg_write
    |=> state.pin_state != $past(state.pin_state))
    else $error("no toggle");

  drive_oe_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_COMPARE || op_select == MODE_PWM |-> !timer_io_pin_oe_n)
    else $error("pin not driven in output mode");

  counter_oe_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_COUNTER |-> timer_io_pin_oe_n)
    else $error("pin driven in counter mode");

  counter_out_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_COUNTER |-> !timer_io_pin_out)
    else $error("invert reached pin in counter mode");

  capture_oe_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_CAPTURE |-> timer_io_pin_oe_n)
    else $error("pin driven in capture mode");

  capture_store_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_CAPTURE && run_bit && capture_hit
    |=> state.cap_evt && state.capture_value == $past(state.count))
    else $error("capture not taken");

  invert_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_COMPARE |-> timer_io_pin_out == (state.pin_state ^ output_invert))
    else $error("polarity wrong");

  pwm_active_lvl_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_PWM && pin_function == FUNC_01
    |-> timer_io_pin_out == (output_level_control ^ output_invert))
    else $error("forced active level wrong");

  pwm_idle_lvl_a: assert property (@(posedge clk_sys) disable iff (srst)
    op_select == MODE_PWM && pin_function == FUNC_00
    |-> timer_io_pin_out == (~output_level_control ^ output_invert))
    else $error("forced inactive level wrong");

  match_low_wr_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_write && reg_addr == ADDR_MATCH_LOW |=> state.compare_a_value[7:0] == $past(reg_wdata))
    else $error("match low byte not written");

  read_count_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_read && reg_addr == ADDR_COUNT_HIGH |=> reg_rdata == $past(state.count[15:8]))
    else $error("count high read wrong");

  read_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
endmodule // stmcr_timer
`default_nettype wire

// ---- stmcr_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module stmcr_pin_model (
  input  wire logic clk_sys,
  input  wire logic tick_en,
  input  wire logic pin_level,
  output var logic  timer_tick,
  output var logic  timer_io_pin_in
);
  initial timer_tick = 1'b0;
  initial timer_io_pin_in = 1'b0;
  // toggling every cycle: slow enough for the 2ff sync to see each edge
  always @(posedge clk_sys) begin
    timer_tick      <= tick_en & ~timer_tick;
    timer_io_pin_in <= pin_level;
  end
endmodule // stmcr_pin_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import stmcr_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r; logic pin; logic oe; bit pc;} stmcr_row_t;
  logic       clk_sys   = 1'b0;
  logic       srst      = 1'b1;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read  = 1'b0;
  logic       tick_en   = 1'b0;
  logic       pin_level = 1'b0;
  logic [7:0] reg_rdata, d, d2;
  logic       timer_tick, timer_io_pin_in, timer_io_pin_out, timer_io_pin_oe_n;
  logic       compare_a_flag, compare_p_flag, capture_event;
  int         err_count = 0;
  int         n_compared = 0;
  int         n_capt = 0;
  int         c, b;
  logic [3:0] lvl = 4'b0010;
  logic [3:0] pex = 4'b1100;
  int         cexp[4] = '{1, 1, 2, 0};
  stmcr_row_t rows[12] = '{
    '{ADDR_MATCH_LOW, 8'h34, 8'h34, 1'b0, 1'b0, 1'b0}, '{ADDR_MATCH_HIGH, 8'h12, 8'h12, 1'b0, 1'b0, 1'b0},
    '{ADDR_PERIOD, 8'h56, 8'h56, 1'b0, 1'b0, 1'b0}, '{ADDR_COUNT_LOW, 8'hff, 8'h00, 1'b0, 1'b0, 1'b0},
    '{ADDR_COUNT_HIGH, 8'hff, 8'h00, 1'b0, 1'b0, 1'b0}, '{ADDR_MODE_OUT, 8'h80, 8'h80, 1'b1, 1'b0, 1'b1},
    '{ADDR_MODE_OUT, 8'h90, 8'h90, 1'b0, 1'b0, 1'b1}, '{ADDR_MODE_OUT, 8'h88, 8'h88, 1'b0, 1'b0, 1'b1},
    '{ADDR_MODE_OUT, 8'h98, 8'h98, 1'b1, 1'b0, 1'b1}, '{ADDR_MODE_OUT, 8'h84, 8'h84, 1'b0, 1'b0, 1'b1},
    '{ADDR_MODE_OUT, 8'h94, 8'h94, 1'b1, 1'b0, 1'b1}, '{ADDR_MODE_OUT, 8'hc0, 8'hc0, 1'b0, 1'b1, 1'b0}};

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (capture_event === 1'b1) n_capt <= n_capt + 1;

  stmcr_timer i_stmcr_timer (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
    .timer_io_pin_in(timer_io_pin_in), .timer_io_pin_out(timer_io_pin_out),
    .timer_io_pin_oe_n(timer_io_pin_oe_n), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag), .capture_event(capture_event));
  stmcr_pin_model i_stmcr_pin_model (.clk_sys(clk_sys), .tick_en(tick_en), .pin_level(pin_level),
    .timer_tick(timer_tick), .timer_io_pin_in(timer_io_pin_in));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // n rising ticks, then flush the sync latency
  task automatic ticks(input int n);
    @(posedge clk_sys);
    tick_en <= 1'b1;
    repeat (2 * n) @(posedge clk_sys);
    tick_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  // bounded wait on a match flag while ticking
  task automatic waitf(input bit use_p, output int n);
    n = 0;
    tick_en <= 1'b1;
    while ((use_p ? compare_p_flag : compare_a_flag) !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    tick_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic restart(input logic [7:0] mode);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_MODE_OUT, mode);
    wr(ADDR_CONTROL, 8'h08);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk("read back", {8'h00, rows[i].r}, {8'h00, d});
      if (rows[i].a == ADDR_MODE_OUT) chk("pin enable", {15'h0, rows[i].oe}, {15'h0, timer_io_pin_oe_n});
      if (rows[i].pc) chk("pin level", {15'h0, rows[i].pin}, {15'h0, timer_io_pin_out});
    end
    // counter mode: run edge zeroes, count per tick, stop keeps residue
    restart(8'hc0);
    ticks(10);
    rd(ADDR_COUNT_LOW, d);
    chk("count", 16'h000a, {8'h00, d});
    wr(ADDR_CONTROL, 8'h00);
    ticks(5);
    rd(ADDR_COUNT_LOW, d2);
    chk("held count", {8'h00, d}, {8'h00, d2});
    // pause freezes the count, release resumes from the residue
    restart(8'hc0);
    wr(ADDR_CONTROL, 8'h88);
    ticks(5);
    rd(ADDR_COUNT_LOW, d);
    chk("paused count", 16'h0000, {8'h00, d});
    wr(ADDR_CONTROL, 8'h08);
    ticks(3);
    rd(ADDR_COUNT_LOW, d);
    chk("resumed count", 16'h0003, {8'h00, d});
    // compare mode, full 16-bit match A at 0x0104, clear on A
    wr(ADDR_MATCH_HIGH, 8'h01);
    wr(ADDR_MATCH_LOW, 8'h04);
    wr(ADDR_PERIOD, 8'h00);
    for (int f = 0; f < 4; f++) begin
      restart({2'b00, f[1:0], lvl[f], 3'b001});
      chk("initial pin", {15'h0, lvl[f]}, {15'h0, timer_io_pin_out});
      waitf(1'b0, c);
      chk("match a delay", 16'h0001, {15'h0, c >= 505 && c <= 545});
      chk("pin after match", {15'h0, pex[f]}, {15'h0, timer_io_pin_out});
      chk("flag p", 16'h0000, {15'h0, compare_p_flag});
      rd(ADDR_COUNT_HIGH, d);
      chk("cleared by a", 16'h0000, {8'h00, d});
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, 8'h08);
      chk("pin restored", {15'h0, lvl[f]}, {15'h0, timer_io_pin_out});
    end
    // period compare on high byte, clear on p
    wr(ADDR_MATCH_HIGH, 8'h03);
    wr(ADDR_PERIOD, 8'h01);
    restart(8'h00);
    waitf(1'b1, c);
    chk("match p delay", 16'h0001, {15'h0, c >= 505 && c <= 545});
    rd(ADDR_COUNT_HIGH, d);
    chk("cleared by p", 16'h0000, {8'h00, d});
    wr(ADDR_PERIOD, 8'h00);
    restart(8'h00);
    ticks(300);
    rd(ADDR_COUNT_HIGH, d);
    chk("no clear at zero period", 16'h0001, {8'h00, d});
    // pwm: swap 1 clears on a, swap 0 with clear source 1 does not
    wr(ADDR_MATCH_HIGH, 8'h00);
    restart(8'haa);
    ticks(20);
    rd(ADDR_COUNT_LOW, d);
    chk("a is period", 16'h0001, {15'h0, d < 8'h05});
    chk("pwm full duty", 16'h0001, {15'h0, timer_io_pin_out});
    restart(8'ha9);
    ticks(20);
    rd(ADDR_COUNT_LOW, d);
    chk("a is duty", 16'h0014, {8'h00, d});
    chk("pwm past duty", 16'h0000, {15'h0, timer_io_pin_out});
    restart(8'hb8);
    chk("pulse start", 16'h0001, {15'h0, timer_io_pin_out});
    ticks(8);
    chk("pulse end", 16'h0000, {15'h0, timer_io_pin_out});
    // capture trigger codes
    for (int f = 0; f < 4; f++) begin
      restart({2'b01, f[1:0], 4'h0});
      b = n_capt;
      pin_level <= 1'b1;
      repeat (8) @(posedge clk_sys);
      pin_level <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk("captures", cexp[f][15:0], n_capt - b);
    end
    // reset in mid-run
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    rd(ADDR_MODE_OUT, d);
    chk("mode after reset", 16'h0000, {8'h00, d});
    chk("pin after reset", 16'h0000, {14'h0, timer_io_pin_out, timer_io_pin_oe_n});
    results();
  end
endmodule // testbench
`default_nettype wire
